// file: logic/svr_supervisor.sv
// What this block does
// - kick input steady for the watchdog period starts a reset pulse.
// - any kick edge clears the watchdog; it stays cleared during reset.
// - watchdog is always active; nothing can disable it.
// - watchdog-caused reset stays asserted for the hold period, then releases.
// - watchdog restarts from zero at reset release; processor must kick in time.
// - with no kicks, resets repeat every watchdog plus hold period.
// - reset held while supply bad, and for the hold period after it returns.
// - supply-good drop asserts reset at once, whatever the watchdog does.
// - every supply-good drop restarts the hold timer from zero.
// - active-high open-drain reset is the exact inverse, driving only when asserted.
// - power-fail warning low when sense below reference or main below switchover.
// - backup above main but main above switchover keeps RAM on main.
// - main below switchover but above backup keeps RAM on main until below backup.
// - RAM returns to main when supply-good becomes true, regardless of backup.
// - RAM return to main precedes reset release by the hold period.
// - hold period nominally 200 ms, within 140 to 280 ms.
// - switchover level sits below reset level; backup entered before RAM too low.
`timescale 1ns/1ps
module svr_supervisor
	import svr_pkg::*;
#(
	parameter int unsigned WD_CYC   = WD_CYC_DEF,
	parameter int unsigned HOLD_CYC = HOLD_CYC_DEF
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// watchdog kick from the processor
	input  wire logic watchdog_kick_in,
	// comparator results
	input  wire logic supply_good_in,
	input  wire logic powerfail_sense_in,
	input  wire logic main_below_switchover_in,
	input  wire logic backup_above_main_in,
	// reset outputs
	output logic      cpu_reset_n,
	output logic      cpu_reset_od_out,
	output logic      cpu_reset_od_oe,
	// power-fail warning and RAM supply select
	output logic      powerfail_warn_n,
	output logic      ram_on_backup_supply
);

	////////////////////////////////////////////////////////////////////////////
	// input synchroniser
	svr_async_in_t async_in;
	svr_async_in_t sync1_reg;
	svr_async_in_t sync1_next;
	svr_async_in_t sync2_reg;
	svr_async_in_t sync2_next;
	logic          kick_prev_reg;
	logic          kick_prev_next;
	logic          kick_edge;

	// the sense input is high when below the reference
	assign async_in = '{kick: watchdog_kick_in, supply_good: supply_good_in,
		sense_below: powerfail_sense_in, main_below_sw: main_below_switchover_in,
		backup_above_main: backup_above_main_in};

	// two stages before any logic reads a pin
	always_comb begin
		sync1_next     = async_in;
		sync2_next     = sync1_reg;
		kick_prev_next = sync2_reg.kick;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_reg     <= ASYNC_IN_RESET;
			sync2_reg     <= ASYNC_IN_RESET;
			kick_prev_reg <= 1'b0;
		end else begin
			sync1_reg     <= sync1_next;
			sync2_reg     <= sync2_next;
			kick_prev_reg <= kick_prev_next;
		end
	end

	// both directions count; edge taken on the synchronised level only
	assign kick_edge = sync2_reg.kick ^ kick_prev_reg;

	////////////////////////////////////////////////////////////////////////////
	// reset sequencer: one counter serves hold and watchdog, states are exclusive
	svr_state_t        state_reg;
	svr_state_t        state_next;
	logic [CNT_W-1:0]  cnt_reg;
	logic [CNT_W-1:0]  cnt_next;
	logic              rst_n_reg;
	logic              rst_n_next;
	logic [CNT_W-1:0]  wd_last;
	logic [CNT_W-1:0]  hold_last;

	assign wd_last   = CNT_W'(WD_CYC - 1);
	assign hold_last = CNT_W'(HOLD_CYC - 1);

	// no enable input exists: the run state always counts toward a timeout
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		if (!sync2_reg.supply_good) begin
			state_next = SVR_SUPPLY_LOW;
			cnt_next   = '0;
		end else begin
			case (state_reg)
				SVR_SUPPLY_LOW: begin
					state_next = SVR_HOLD;
					cnt_next   = '0;
				end
				SVR_HOLD: begin
					if (cnt_reg >= hold_last) begin
						state_next = SVR_RUN;
						cnt_next   = '0;
					end else begin
						cnt_next = cnt_reg + 1'b1;
					end
				end
				SVR_RUN: begin
					if (kick_edge) begin
						cnt_next = '0;
					end else if (cnt_reg >= wd_last) begin
						state_next = SVR_HOLD;
						cnt_next   = '0;
					end else begin
						cnt_next = cnt_reg + 1'b1;
					end
				end
				default: begin
					state_next = SVR_SUPPLY_LOW;
					cnt_next   = '0;
				end
			endcase
		end
		// registered so the pin never glitches on decode
		rst_n_next = (state_next == SVR_RUN);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= SVR_SUPPLY_LOW;
			cnt_reg   <= '0;
			rst_n_reg <= RST_N_RESET;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			rst_n_reg <= rst_n_next;
		end
	end

	assign cpu_reset_n      = rst_n_reg;
	// open drain: level is constant, only the enable moves
	assign cpu_reset_od_out = 1'b1;
	assign cpu_reset_od_oe  = ~rst_n_reg;

	////////////////////////////////////////////////////////////////////////////
	// power-fail warning and RAM supply select
	logic warn_n_reg;
	logic warn_n_next;
	logic backup_reg;
	logic backup_next;

	// comparator hysteresis lives upstream; this only applies the ordering
	always_comb begin
		warn_n_next = ~(sync2_reg.sense_below | sync2_reg.main_below_sw);
		backup_next = backup_reg;
		if (sync2_reg.supply_good) begin
			backup_next = 1'b0;
		end else if (sync2_reg.main_below_sw && sync2_reg.backup_above_main) begin
			backup_next = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			warn_n_reg <= WARN_N_RESET;
			backup_reg <= BACKUP_RESET;
		end else begin
			warn_n_reg <= warn_n_next;
			backup_reg <= backup_next;
		end
	end

	assign powerfail_warn_n     = warn_n_reg;
	assign ram_on_backup_supply = backup_reg;

	////////////////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_wd_expire;
		state_reg == SVR_RUN && cnt_reg == wd_last && !kick_edge && sync2_reg.supply_good;
	endsequence

	sequence s_hold_done;
		state_reg == SVR_HOLD && cnt_reg == hold_last && sync2_reg.supply_good;
	endsequence

	property p_wd_timeout;
		s_wd_expire |=> state_reg == SVR_HOLD && cnt_reg == '0 && !cpu_reset_n;
	endproperty
	a_wd_timeout: assert property (p_wd_timeout)
		else $error("watchdog expiry did not start reset hold");

	property p_kick_clears;
		state_reg == SVR_RUN && kick_edge && sync2_reg.supply_good |=> cnt_reg == '0;
	endproperty
	a_kick_clears: assert property (p_kick_clears)
		else $error("kick edge did not clear watchdog");

	property p_wd_counts;
		state_reg == SVR_RUN && !kick_edge && sync2_reg.supply_good && cnt_reg < wd_last
			|=> state_reg == SVR_RUN && cnt_reg == $past(cnt_reg) + 1'b1;
	endproperty
	a_wd_counts: assert property (p_wd_counts)
		else $error("watchdog stopped counting");

	property p_hold_release;
		s_hold_done |=> state_reg == SVR_RUN && cpu_reset_n && cnt_reg == '0;
	endproperty
	a_hold_release: assert property (p_hold_release)
		else $error("reset not released after hold period");

	property p_reset_only_run;
		cpu_reset_n == (state_reg == SVR_RUN);
	endproperty
	a_reset_only_run: assert property (p_reset_only_run)
		else $error("reset output disagrees with sequencer state");

	property p_brownout;
		!sync2_reg.supply_good |=> !cpu_reset_n && cnt_reg == '0 && state_reg == SVR_SUPPLY_LOW;
	endproperty
	a_brownout: assert property (p_brownout)
		else $error("supply drop did not assert reset and clear hold");

	property p_good_return;
		$rose(sync2_reg.supply_good) |=> state_reg == SVR_HOLD && cnt_reg == '0 && !ram_on_backup_supply;
	endproperty
	a_good_return: assert property (p_good_return)
		else $error("supply return did not restart hold or restore main");

	property p_od_inverse;
		cpu_reset_od_oe == !cpu_reset_n && cpu_reset_od_out;
	endproperty
	a_od_inverse: assert property (p_od_inverse)
		else $error("open-drain reset not inverse of active-low reset");

	property p_warn;
		!rst |=> powerfail_warn_n == !($past(sync2_reg.sense_below) || $past(sync2_reg.main_below_sw));
	endproperty
	a_warn: assert property (p_warn)
		else $error("power-fail warning wrong");

	property p_stay_main;
		!ram_on_backup_supply && !(sync2_reg.main_below_sw && sync2_reg.backup_above_main)
			|=> !ram_on_backup_supply;
	endproperty
	a_stay_main: assert property (p_stay_main)
		else $error("RAM switched to backup too early");

	property p_main_before_release;
		$rose(cpu_reset_n) |-> !ram_on_backup_supply && $past(state_reg) == SVR_HOLD;
	endproperty
	a_main_before_release: assert property (p_main_before_release)
		else $error("reset released while RAM on backup");

	property p_wd_rearm;
		$rose(cpu_reset_n) |-> cnt_reg == '0;
	endproperty
	a_wd_rearm: assert property (p_wd_rearm)
		else $error("watchdog did not restart from zero at reset release");

	property p_hold_counts;
		state_reg == SVR_HOLD && sync2_reg.supply_good && cnt_reg < hold_last
			|=> state_reg == SVR_HOLD && cnt_reg == $past(cnt_reg) + 1'b1 && !cpu_reset_n;
	endproperty
	a_hold_counts: assert property (p_hold_counts)
		else $error("hold period did not count while reset held");

	property p_hold_bound;
		state_reg == SVR_HOLD |-> cnt_reg <= hold_last;
	endproperty
	a_hold_bound: assert property (p_hold_bound)
		else $error("hold counter ran past the hold period");

	property p_wd_bound;
		state_reg == SVR_RUN |-> cnt_reg <= wd_last;
	endproperty
	a_wd_bound: assert property (p_wd_bound)
		else $error("watchdog counter ran past the watchdog period");

	sequence s_backup_cond;
		!sync2_reg.supply_good && sync2_reg.main_below_sw && sync2_reg.backup_above_main;
	endsequence

	property p_backup_enter;
		s_backup_cond |=> ram_on_backup_supply;
	endproperty
	a_backup_enter: assert property (p_backup_enter)
		else $error("RAM not switched to backup below switchover and backup");

	property p_main_when_good;
		sync2_reg.supply_good |=> !ram_on_backup_supply;
	endproperty
	a_main_when_good: assert property (p_main_when_good)
		else $error("RAM left on backup while supply good");

	property p_sync_chain;
		!rst |=> sync2_reg == $past(sync1_reg) && kick_prev_reg == $past(sync2_reg.kick);
	endproperty
	a_sync_chain: assert property (p_sync_chain)
		else $error("input synchroniser stages out of step");

endmodule

// file: logic/svr_pkg.sv
package svr_pkg;
	// clock and printed times
	localparam int unsigned CLK_HZ         = 25_000_000;
	localparam int unsigned CLK_KHZ        = CLK_HZ / 1000;
	localparam int unsigned WD_PERIOD_MS   = 1600;
	localparam int unsigned HOLD_PERIOD_MS = 200;
	localparam int unsigned HOLD_MIN_MS    = 140;
	localparam int unsigned HOLD_MAX_MS    = 280;

	// cycle counts derived from the times (both above 4096, so module parameters)
	localparam int unsigned WD_CYC_DEF   = WD_PERIOD_MS * CLK_KHZ;
	localparam int unsigned HOLD_CYC_DEF = HOLD_PERIOD_MS * CLK_KHZ;

	// counter width covers the longer period
	localparam int unsigned CNT_W = 32;

	// reset values
	localparam logic RST_N_RESET  = 1'b0;
	localparam logic WARN_N_RESET = 1'b0;
	localparam logic BACKUP_RESET = 1'b0;

	// comparator and pin inputs that cross into the clock domain
	typedef struct packed {
		logic kick;
		logic supply_good;
		logic sense_below;
		logic main_below_sw;
		logic backup_above_main;
	} svr_async_in_t;

	localparam svr_async_in_t ASYNC_IN_RESET = '0;

	// reset sequencer states, gray along supply low -> hold -> run
	typedef enum logic [1:0] {
		SVR_SUPPLY_LOW = 2'h0,
		SVR_HOLD       = 2'h1,
		SVR_RUN        = 2'h3
	} svr_state_t;
endpackage

// file: testbench/svr_cpu_model.sv
`timescale 1ns/1ps
module svr_cpu_model (
	// clock and reset seen by the processor
	input  wire logic clk,
	input  wire logic cpu_reset_n,
	// bench control: firmware alive or hung
	input  wire logic kick_en,
	// kick to the supervisor
	output logic      watchdog_kick_in
);
	logic [4:0] gap_reg  = 5'h00;
	logic       kick_reg = 1'b0;
	// one driver for the pin, the register below
	assign watchdog_kick_in = kick_reg;
	////////////////////////////////////////////////////////////
	// firmware toggles every 20 cycles, well inside the period
	// a processor held in reset runs no code, so no kicks then
	always @(posedge clk) begin
		gap_reg <= (gap_reg == 5'h13) ? 5'h00 : gap_reg + 5'h01;
		if (kick_en && cpu_reset_n && gap_reg == 5'h13) begin
			kick_reg <= ~kick_reg;
		end
	end
endmodule

// file: testbench/svr_supervisor_tb_top.sv
`timescale 1ns/1ps
module svr_supervisor_tb_top;
	localparam int WD = 64;
	localparam int HD = 16;
	logic clk, rst, kick_en, sg, sense, mbs, bam;
	logic kick, rn, od_out, od_oe, warn_n, bkp;
	int   err_total, checked, n, i;
	// open drain line with pull-down: high only while driven
	wire  reset_hi = od_oe ? od_out : 1'b0;

	svr_supervisor #(.WD_CYC(WD), .HOLD_CYC(HD)) i_svr_supervisor (
		.clk(clk), .rst(rst), .watchdog_kick_in(kick), .supply_good_in(sg),
		.powerfail_sense_in(sense), .main_below_switchover_in(mbs), .backup_above_main_in(bam),
		.cpu_reset_n(rn), .cpu_reset_od_out(od_out), .cpu_reset_od_oe(od_oe),
		.powerfail_warn_n(warn_n), .ram_on_backup_supply(bkp));
	svr_cpu_model i_svr_cpu_model (.clk(clk), .cpu_reset_n(rn), .kick_en(kick_en), .watchdog_kick_in(kick));

	////////////////////////////////////////////////////////////
	// clock, 40 ns period
	initial clk = 1'b0;
	always #20 clk = ~clk;

	task automatic report_and_stop();
		if (err_total == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string nm, input logic exp, input logic got);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %b seen %b", nm, exp, got);
		end
	endtask
	task automatic rng(input string nm, input int v, input int lo, input int hi);
		checked++;
		if (v < lo || v > hi) begin
			err_total++;
			$display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, v);
		end
	endtask
	// counts cycles the reset output stays at lvl, sampled mid-cycle
	task automatic meas(input logic lvl, output int c);
		c = 0;
		while (rn === lvl && c < 1000) begin
			@(negedge clk);
			c++;
		end
	endtask
	task automatic wait_n(input int c);
		repeat (c) @(negedge clk);
	endtask

	////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_power_up();
		@(posedge clk) sg <= 1'b1;
		wait_n(1);
		chk("reset_hi", 1'b1, reset_hi);
		meas(1'b0, n);
		rng("hold after supply good", n, HD + 2, HD + 4);
		chk("ram_backup", 1'b0, bkp);
		chk("reset_hi", 1'b0, reset_hi);
	endtask
	task automatic t_kicked();
		@(posedge clk) kick_en <= 1'b1;
		for (i = 0; i < 3 * WD; i++) begin
			@(negedge clk);
			chk("reset while kicked", 1'b1, rn);
		end
	endtask
	task automatic t_timeout();
		@(posedge clk) kick_en <= 1'b0;
		meas(1'b1, n);
		rng("first timeout", n, 1, WD + 24);
		chk("reset_hi", 1'b1, reset_hi);
		meas(1'b0, n);
		rng("watchdog hold", n, HD - 1, HD + 1);
		meas(1'b1, n);
		rng("watchdog period", n, WD - 1, WD + 1);
		meas(1'b0, n);
		rng("repeat hold", n, HD - 1, HD + 1);
		@(posedge clk) kick_en <= 1'b1;
	endtask
	task automatic t_brownout();
		@(posedge clk) {sg, mbs, bam} <= 3'h2;
		wait_n(4);
		chk("brownout reset", 1'b0, rn);
		chk("ram_backup main above backup", 1'b0, bkp);
		@(posedge clk) bam <= 1'b1;
		wait_n(4);
		chk("reset_hi", 1'b1, reset_hi);
		chk("ram_backup", 1'b1, bkp);
		@(posedge clk) sg <= 1'b1;
		wait_n(8);
		@(posedge clk) sg <= 1'b0;
		wait_n(4);
		@(posedge clk) sg <= 1'b1;
		wait_n(4);
		chk("ram back to main", 1'b0, bkp);
		chk("reset still held", 1'b0, rn);
		meas(1'b0, n);
		rng("hold restarted", n, HD - 2, HD);
		@(posedge clk) {sg, mbs, bam} <= 3'h1;
		wait_n(5);
		chk("ram_backup above switchover", 1'b0, bkp);
		@(posedge clk) {sg, bam} <= 2'h2;
		wait_n(4);
		meas(1'b0, n);
		rng("hold after brownout", n, HD - 1, HD + 1);
	endtask
	task automatic t_warn();
		for (i = 0; i < 4; i++) begin
			@(posedge clk) {sense, mbs} <= i[1:0];
			wait_n(4);
			chk("powerfail_warn_n", ~(i[1] | i[0]), warn_n);
		end
	endtask

	////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{rst, kick_en, sg, sense, mbs, bam} = 6'h20;
		err_total = 0;
		checked = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_power_up();
		t_kicked();
		t_timeout();
		t_brownout();
		t_warn();
		report_and_stop();
	end
	// hang guard, far beyond the few hundred cycles the run needs
	initial begin
		#(40 * 20000);
		err_total++;
		report_and_stop();
	end
endmodule
